// ### cpmld_pkg.sv
// ----------------------------------------------------------------
// Charge pump mode and lock detect: shared constants and types
// ----------------------------------------------------------------
package cpmld_pkg;

    // APB register byte offsets
    localparam logic [7:0] CPMLD_CTRL_OFS = 8'h00;
    localparam logic [7:0] CPMLD_GAIN_OFS = 8'h04;
    localparam logic [7:0] CPMLD_STAT_OFS = 8'h08;
    localparam logic [7:0] CPMLD_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] CPMLD_IRQ_MASK_OFS = 8'h10;

    // Field positions inside the status word
    localparam int CPMLD_STAT_LOCK_BIT = 0;
    localparam int CPMLD_STAT_SPEEDUP_BIT = 1;
    localparam int CPMLD_STAT_ACC_LSB = 4;

    // Interrupt status and mask bit positions
    localparam int CPMLD_IRQ_LOCK_GAIN = 0;
    localparam int CPMLD_IRQ_LOCK_LOSS = 1;
    localparam int CPMLD_IRQ_ACC_WRAP = 2;
    localparam int CPMLD_IRQ_BITS = 3;

    // Values after reset
    localparam logic [5:0] CPMLD_CTRL_RST = 6'h00;
    localparam logic [13:0] CPMLD_GAIN_RST = 14'h0000;
    localparam logic [2:0] CPMLD_MASK_RST = 3'h0;

    // Fractional modulus for each setting of the modulus select bit
    localparam logic [3:0] CPMLD_Q_WIDE = 4'h8;
    localparam logic [3:0] CPMLD_Q_NARROW = 4'h5;

    // Compensation window length in reference input cycles
    localparam int CPMLD_WIN_STAGES = 3;

    // Control word: bits [5:0] of the control register
    typedef struct packed {
        logic [2:0] fraction_step;
        logic modulus_select;
        logic aux_path_enable;
        logic main_path_enable;
    } cpmld_ctrl_t;

    // Gain word: bits [13:0] of the gain register
    typedef struct packed {
        logic [3:0] integral_gain_code;
        logic [1:0] speedup_shift_code;
        logic [7:0] pump_gain_code;
    } cpmld_gain_t;

    // Scaled codes to the analog pump DACs
    typedef struct packed {
        logic [12:0] prop_pump_code;
        logic [7:0] prop_comp_code;
        logic [15:0] int_pump_code;
        logic [10:0] int_comp_code;
    } cpmld_dac_t;

    // Pump switch enables driven from the main phase detector
    typedef struct packed {
        logic prop_up;
        logic prop_down;
        logic int_up;
        logic int_down;
    } cpmld_pump_t;

endpackage

// ### cpmld_core.sv
`timescale 1ns/1ns
// How it works
// - Pumps driven by main detector, DAC-scaled magnitudes
// - Compensation from accumulator, DAC codes, reference timing
// - Compensation one reference cycle either side
// - Speed-up while latch high after A word
// - Normal proportional: gain code plus compensation
// - Compensation term is accumulator over 128
// - Integral pump zero in normal mode
// - Speed-up adds terms scaled by 2^(shift+1)
// - Integral speed-up terms times integral gain
// - Lock flag needs both detectors locked
// - Lock means within one reference cycle
// - Disabled path counts as locked
// - Accumulator adds step modulo Q on each main divider pulse
// - Main counter runs only when enabled
module cpmld_core (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic reference_input_in,
    input wire logic ref_div_early_in,
    input wire logic aux_ref_pulse_in,
    input wire logic main_div_pulse_in,
    input wire logic aux_div_pulse_in,
    input wire logic serial_latch_in,
    input wire logic a_word_loaded_in,
    output cpmld_pkg::cpmld_dac_t dac_out,
    output cpmld_pkg::cpmld_pump_t pump_out,
    output logic main_cmp_pulse_out,
    output logic comp_en_out,
    output logic lock_out,
    output logic irq_out
);
    import cpmld_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cpmld_ctrl_t ctrl_reg, ctrl_next;
    cpmld_gain_t gain_reg, gain_next;
    cpmld_dac_t dac_reg, dac_next;
    cpmld_pump_t pump_reg, pump_next;
    logic [2:0] mask_reg, mask_next;
    logic [2:0] irq_stat_reg, irq_stat_next;
    logic [2:0] irq_ev;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic ref_q_reg, ref_edge;
    logic speedup_reg, speedup_next;
    logic [2:0] acc_reg, acc_next;
    logic [3:0] acc_sum, q_val;
    logic acc_wrap, main_div_ev;
    logic [CPMLD_WIN_STAGES-1:0] win_reg, win_next;
    logic comp_en_reg, comp_en_next;
    logic lock_reg, lock_next;
    logic [4:0] pow_val, mult_val;
    logic [1:0] det_ref_ev, det_div_ev, det_en, det_lock;
    logic [1:0] det_pr_next, det_pd_next;
    logic apb_setup, apb_access;

    // ------------------------------------------------------------
    // APB slave, registers and interrupt status
    // ------------------------------------------------------------
    // Read data is latched in the setup cycle, so every answer has one wait-free access
    always_comb begin
        apb_setup = psel_in && !penable_in;
        apb_access = psel_in && penable_in && pready_reg;
        ctrl_next = ctrl_reg;
        gain_next = gain_reg;
        mask_next = mask_reg;
        irq_stat_next = irq_stat_reg | irq_ev;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        pready_next = apb_setup;
        if (apb_setup) begin
            pslverr_next = 1'b0;
            prdata_next = 32'h0000_0000;
            case (paddr_in)
                CPMLD_CTRL_OFS: prdata_next[5:0] = ctrl_reg;
                CPMLD_GAIN_OFS: prdata_next[13:0] = gain_reg;
                CPMLD_STAT_OFS: begin
                    prdata_next[CPMLD_STAT_LOCK_BIT] = lock_reg;
                    prdata_next[CPMLD_STAT_SPEEDUP_BIT] = speedup_reg;
                    prdata_next[CPMLD_STAT_ACC_LSB +: 3] = acc_reg;
                end
                CPMLD_IRQ_STAT_OFS: prdata_next[2:0] = irq_stat_reg;
                CPMLD_IRQ_MASK_OFS: prdata_next[2:0] = mask_reg;
                default: pslverr_next = 1'b1;
            endcase
        end
        if (apb_access && pwrite_in && !pslverr_reg) begin
            case (paddr_in)
                CPMLD_CTRL_OFS: ctrl_next = pwdata_in[5:0];
                CPMLD_GAIN_OFS: gain_next = pwdata_in[13:0];
                CPMLD_IRQ_MASK_OFS: mask_next = pwdata_in[2:0];
                default: ;
            endcase
        end
        // Read clears only the bits it returned, so a later event is never lost
        if (apb_access && !pwrite_in && paddr_in == CPMLD_IRQ_STAT_OFS) begin
            irq_stat_next = (irq_stat_reg & ~prdata_reg[2:0]) | irq_ev;
        end
        irq_next = |(irq_stat_next & mask_next);
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= CPMLD_CTRL_RST;
            gain_reg <= CPMLD_GAIN_RST;
            mask_reg <= CPMLD_MASK_RST;
            irq_stat_reg <= 3'h0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            gain_reg <= gain_next;
            mask_reg <= mask_next;
            irq_stat_reg <= irq_stat_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // Mode, fractional accumulator, window and DAC codes
    // ------------------------------------------------------------
    // Reference input is synchronous, so a one-flop edge detect is safe
    always_comb begin
        ref_edge = reference_input_in && !ref_q_reg;
        speedup_next = serial_latch_in && (speedup_reg || a_word_loaded_in);
        main_div_ev = main_div_pulse_in && ctrl_reg.main_path_enable;
        q_val = ctrl_reg.modulus_select ? CPMLD_Q_WIDE : CPMLD_Q_NARROW;
        acc_sum = {1'b0, acc_reg} + {1'b0, ctrl_reg.fraction_step};
        acc_wrap = main_div_ev && (acc_sum >= q_val);
        acc_next = main_div_ev ? 3'(acc_sum % q_val) : acc_reg;
        // Stage 0 is the cycle before the comparator pulse, stage 2 the one after
        win_next = ref_edge ? {win_reg[1:0], ref_div_early_in} : win_reg;
        comp_en_next = (|win_next) && (acc_next != 3'h0);
        pow_val = 5'h01 << ({3'h0, gain_reg.speedup_shift_code} + 5'h01);
        mult_val = speedup_reg ? (5'h01 + pow_val) : 5'h01;
        dac_next = dac_reg;
        // Codes move only on reference edges so the pumps never glitch mid-cycle
        if (ref_edge) begin
            dac_next.prop_pump_code = 13'(gain_reg.pump_gain_code) * 13'(mult_val);
            dac_next.prop_comp_code = 8'(acc_reg) * 8'(mult_val);
            if (speedup_reg) begin
                dac_next.int_pump_code = 16'(gain_reg.pump_gain_code) * 16'(pow_val)
                    * 16'(gain_reg.integral_gain_code);
                dac_next.int_comp_code = 11'(acc_reg) * 11'(pow_val)
                    * 11'(gain_reg.integral_gain_code);
            end else begin
                dac_next.int_pump_code = 16'h0000;
                dac_next.int_comp_code = 11'h000;
            end
        end
        // Integral switches follow the detector only in speed-up mode
        pump_next.prop_up = det_pr_next[0];
        pump_next.prop_down = det_pd_next[0];
        pump_next.int_up = det_pr_next[0] && speedup_next;
        pump_next.int_down = det_pd_next[0] && speedup_next;
        lock_next = (det_lock[0] || !det_en[0]) && (det_lock[1] || !det_en[1]);
        irq_ev = '0;
        irq_ev[CPMLD_IRQ_LOCK_GAIN] = lock_next && !lock_reg;
        irq_ev[CPMLD_IRQ_LOCK_LOSS] = !lock_next && lock_reg;
        irq_ev[CPMLD_IRQ_ACC_WRAP] = acc_wrap;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ref_q_reg <= 1'b0;
            speedup_reg <= 1'b0;
            acc_reg <= 3'h0;
            win_reg <= '0;
            comp_en_reg <= 1'b0;
            dac_reg <= '0;
            pump_reg <= '0;
            lock_reg <= 1'b0;
        end else begin
            ref_q_reg <= reference_input_in;
            speedup_reg <= speedup_next;
            acc_reg <= acc_next;
            win_reg <= win_next;
            comp_en_reg <= comp_en_next;
            dac_reg <= dac_next;
            pump_reg <= pump_next;
            lock_reg <= lock_next;
        end
    end

    // ------------------------------------------------------------
    // Phase detectors: index 0 main, index 1 auxiliary
    // ------------------------------------------------------------
    assign det_en = {ctrl_reg.aux_path_enable, ctrl_reg.main_path_enable};
    assign det_ref_ev = {aux_ref_pulse_in, ref_edge && win_reg[0]};
    assign det_div_ev = {aux_div_pulse_in && det_en[1], main_div_ev};

    for (genvar i = 0; i < 2; i++) begin : g_det
        logic pr_reg, pr_next, pd_reg, pd_next, aged_reg, aged_next, lk_reg, lk_next;

        // Lock holds when the partner edge comes before the next reference edge
        always_comb begin
            pr_next = pr_reg;
            pd_next = pd_reg;
            aged_next = aged_reg;
            lk_next = lk_reg;
            if (!det_en[i]) begin
                pr_next = 1'b0;
                pd_next = 1'b0;
                aged_next = 1'b0;
            end else if (det_ref_ev[i] && det_div_ev[i]) begin
                pr_next = 1'b0;
                pd_next = 1'b0;
                lk_next = 1'b1;
            end else if (det_ref_ev[i] || det_div_ev[i]) begin
                if ((det_ref_ev[i] && pd_reg) || (det_div_ev[i] && pr_reg)) begin
                    lk_next = !aged_reg;
                    pr_next = 1'b0;
                    pd_next = 1'b0;
                end else begin
                    lk_next = lk_reg && !(pr_reg || pd_reg);
                    pr_next = det_ref_ev[i];
                    pd_next = det_div_ev[i];
                end
                aged_next = 1'b0;
            end else if (ref_edge && (pr_reg || pd_reg)) begin
                if (aged_reg) begin
                    lk_next = 1'b0;
                    pr_next = 1'b0;
                    pd_next = 1'b0;
                end
                aged_next = 1'b1;
            end
        end

        always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
                pr_reg <= 1'b0;
                pd_reg <= 1'b0;
                aged_reg <= 1'b0;
                lk_reg <= 1'b0;
            end else begin
                pr_reg <= pr_next;
                pd_reg <= pd_next;
                aged_reg <= aged_next;
                lk_reg <= lk_next;
            end
        end

        assign det_lock[i] = lk_reg;
        assign det_pr_next[i] = pr_next;
        assign det_pd_next[i] = pd_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign dac_out = dac_reg;
    assign pump_out = pump_reg;
    assign main_cmp_pulse_out = win_reg[1];
    assign comp_en_out = comp_en_reg;
    assign lock_out = lock_reg;
    assign irq_out = irq_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_speedup_exit: assert property (!serial_latch_in |=> !speedup_reg)
        else $error("speed-up mode kept with latch low");
    a_int_zero_normal: assert property (ref_edge && !speedup_reg |=>
        dac_out.int_pump_code == 16'h0000 && dac_out.int_comp_code == 11'h000)
        else $error("integral pump active in normal mode");
    a_prop_normal: assert property (ref_edge && !speedup_reg |=>
        dac_out.prop_pump_code == 13'($past(gain_reg.pump_gain_code)))
        else $error("normal proportional code wrong");
    a_comp_normal: assert property (ref_edge && !speedup_reg |=>
        dac_out.prop_comp_code == 8'($past(acc_reg)))
        else $error("normal compensation code wrong");
    a_prop_speedup: assert property (ref_edge && speedup_reg
        && gain_reg.speedup_shift_code == 2'h0
        |=> dac_out.prop_pump_code == 13'($past(gain_reg.pump_gain_code)) * 13'h0003)
        else $error("speed-up proportional code wrong");
    a_int_speedup: assert property (ref_edge && speedup_reg
        && gain_reg.speedup_shift_code == 2'h1
        |=> dac_out.int_pump_code == 16'($past(gain_reg.pump_gain_code)) * 16'h0004
        * 16'($past(gain_reg.integral_gain_code)))
        else $error("speed-up integral code wrong");
    a_lock_needs_both: assert property (det_en[1] && !det_lock[1] |=> !lock_out)
        else $error("lock flag high with auxiliary unlocked");
    a_disabled_locked: assert property (!det_en[0] && !det_en[1] |=> lock_out)
        else $error("disabled paths not counted as locked");
    a_acc_modulo: assert property (main_div_ev && ctrl_reg.modulus_select |=>
        acc_reg == 3'(({1'b0, $past(acc_reg)} + {1'b0, $past(ctrl_reg.fraction_step)}) % 4'h8))
        else $error("accumulator not stepped modulo eight");
    a_acc_hold_off: assert property (!ctrl_reg.main_path_enable |=> $stable(acc_reg))
        else $error("accumulator moved with main path off");
    a_window_centre: assert property (
        main_cmp_pulse_out && acc_reg != 3'h0 |-> comp_en_out)
        else $error("compensation off around comparator pulse");
    a_window_zero_acc: assert property (acc_reg == 3'h0 |-> !comp_en_out)
        else $error("compensation on with empty accumulator");
    a_dac_ref_edge: assert property (!ref_edge |=> $stable(dac_out))
        else $error("DAC codes changed between reference edges");
    a_pump_from_main: assert property (##1 pump_out.prop_up == $past(det_pr_next[0]))
        else $error("proportional up not following main detector");

    c_speedup_entry: cover property (a_word_loaded_in && serial_latch_in ##1 speedup_reg);
    c_lock_gain: cover property (!lock_out ##1 lock_out && det_en == 2'h3);
    c_comp_window: cover property (comp_en_out [*3]);
    c_irq_raise: cover property (!irq_out ##1 irq_out);

endmodule // cpmld_core

// ### cpmld_vco_model.sv
`timescale 1ns/1ns
// Far-side divider model: answers each reference event after a short lag
module cpmld_vco_model (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic main_cmp_in,
    input wire logic aux_ref_in,
    input wire logic drop_main_in,
    input wire logic drop_aux_in,
    output logic main_div_out,
    output logic aux_div_out
);
    logic cmp_d_reg;
    logic aux_d_reg;
    // Lags stay below one reference cycle; a drop is only on bench command
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cmp_d_reg <= 1'b0;
            aux_d_reg <= 1'b0;
            main_div_out <= 1'b0;
            aux_div_out <= 1'b0;
        end else begin
            cmp_d_reg <= main_cmp_in;
            main_div_out <= main_cmp_in && !cmp_d_reg && !drop_main_in;
            aux_d_reg <= aux_ref_in && !drop_aux_in;
            aux_div_out <= aux_d_reg;
        end
    end
endmodule // cpmld_vco_model

// ### cpmld_core_tb.sv
`timescale 1ns/1ns
module cpmld_core_tb;
    import cpmld_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cpmld_note_t;
    cpmld_note_t notes[$];
    cpmld_note_t nt;
    logic clk, rst, psel, penable, pwrite, early, aux_ref, latch, a_word;
    logic pready, pslverr, main_div, aux_div, main_cmp, comp_en, lock, irq;
    logic drop_main, drop_aux, win_chk, wrap;
    logic [7:0] paddr, lfsr, cn;
    logic [31:0] pwdata, prdata;
    logic [4:0] per;
    logic [3:0] ck;
    logic [1:0] cl;
    logic [2:0] acc;
    cpmld_dac_t dac;
    cpmld_pump_t pump;
    int req, done, run, cmp_run, up_run, rises, cycles, num_errors, n_compared, q, k0;
    logic [5:0] acc_ctrl [3] = '{6'b011011, 6'b101111, 6'b110010};
    logic [4:0] lk [5] = '{5'b11100, 5'b10101, 5'b11010, 5'b01011, 5'b11001};

    cpmld_core DUT (
        .core_clk_in(clk),
        .sys_rst_in(rst),
        .psel_in(psel),
        .penable_in(penable),
        .pwrite_in(pwrite),
        .paddr_in(paddr),
        .pwdata_in(pwdata),
        .prdata_out(prdata),
        .pready_out(pready),
        .pslverr_out(pslverr),
        .reference_input_in(per[1]),
        .ref_div_early_in(early),
        .aux_ref_pulse_in(aux_ref),
        .main_div_pulse_in(main_div),
        .aux_div_pulse_in(aux_div),
        .serial_latch_in(latch),
        .a_word_loaded_in(a_word),
        .dac_out(dac),
        .pump_out(pump),
        .main_cmp_pulse_out(main_cmp),
        .comp_en_out(comp_en),
        .lock_out(lock),
        .irq_out(irq)
    );
    cpmld_vco_model far_side (
        .core_clk_in(clk),
        .sys_rst_in(rst),
        .main_cmp_in(main_cmp),
        .aux_ref_in(aux_ref),
        .drop_main_in(drop_main),
        .drop_aux_in(drop_aux),
        .main_div_out(main_div),
        .aux_div_out(aux_div)
    );

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic check(input logic [47:0] s, input logic [47:0] e, input string w);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h want %h", $time, w, s, e);
        end
    endtask
    task automatic stop_test();
        $display("Counts: %0d mismatches, %0d compared", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bus cycle: setup, then access held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic er);
        notes.push_back('{e, m, er});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No own limit: only the bench timeout may end this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask
    // Requests n comparator events, starting clear of a reference period
    task automatic pulses(input int n);
        while (per !== 5'h10) begin
            @(posedge clk);
        end
        req <= req + n;
        do begin
            @(posedge clk);
        end while (done != req);
        repeat (32) @(posedge clk);
    endtask
    function automatic cpmld_dac_t exp_dac(input logic sp);
        int p;
        int mu;
        cpmld_dac_t r;
        p = 1 << (cl + 1);
        mu = sp ? 1 + p : 1;
        r.prop_pump_code = 13'(cn * mu);
        r.prop_comp_code = 8'(acc * mu);
        r.int_pump_code = sp ? 16'(cn * p * ck) : 16'h0000;
        r.int_comp_code = sp ? 11'(acc * p * ck) : 11'h000;
        return r;
    endfunction
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Reference timing: 4-clock reference cycle, early level, aux event
    always @(posedge clk) begin
        if (rst) begin
            per <= 5'h00;
            done <= 0;
            early <= 1'b0;
            aux_ref <= 1'b0;
        end else begin
            per <= per + 5'h01;
            early <= (per == 5'h1f || per < 5'h03) && done != req;
            aux_ref <= per == 5'h0f && done != req;
            if (per == 5'h03 && done != req) done <= done + 1;
        end
    end
    // Answer watcher takes the oldest note at each completed transfer
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            check(prdata & nt.m, nt.d & nt.m, "read data");
            check(pslverr, nt.e, "slave error");
        end
    end
    // Ceiling far above the under two thousand cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // Window, comparator and pump pulse lengths, in core cycles
    always @(posedge clk) begin
        if (pump.prop_up === 1'b1) begin
            up_run <= up_run + 1;
        end else begin
            if (up_run != 0) check(48'(up_run), drop_main ? 48'd8 : 48'd2, "pump");
            up_run <= 0;
        end
        if (comp_en === 1'b1) begin
            run <= run + 1;
            if (run == 0) rises <= rises + 1;
        end else begin
            if (run != 0 && win_chk) check(48'(run), 48'd12, "window");
            run <= 0;
        end
        if (main_cmp === 1'b1) begin
            cmp_run <= cmp_run + 1;
        end else begin
            if (cmp_run != 0) check(48'(cmp_run), 48'd4, "cmp pulse");
            cmp_run <= 0;
        end
    end

    initial begin
        {rst, psel, penable, pwrite, latch, a_word, drop_main, drop_aux, win_chk} = 9'h100;
        {paddr, pwdata, req, run, cmp_run, up_run, rises, cycles, num_errors, n_compared} = '0;
        lfsr = 8'h50;
        acc = 3'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(CPMLD_CTRL_OFS, 32'hffffffff, 32'h0);
        rd(CPMLD_GAIN_OFS, 32'hffffffff, 32'h0);
        rd(CPMLD_IRQ_MASK_OFS, 32'hffffffff, 32'h0);
        rd(CPMLD_STAT_OFS, 32'h73, 32'h1);
        // Lock rises right after reset with both paths off, so the gain bit is set
        rd(CPMLD_IRQ_STAT_OFS, 32'h7, 32'h1);
        apb(1'b0, 8'h14, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b1, 8'h14, 32'h1, 32'h0, 32'h0, 1'b1);
        wr(CPMLD_STAT_OFS, 32'hffffffff);
        rd(CPMLD_STAT_OFS, 32'h72, 32'h0);
        wr(CPMLD_CTRL_OFS, 32'h3);
        pulses(2);
        check(48'(rises), 48'd0, "window at zero");
        check(lock, 1'b1, "lock both");
        for (int i = 0; i < 3; i++) begin
            wrap = 1'b0;
            q = acc_ctrl[i][2] ? 8 : 5;
            wr(CPMLD_CTRL_OFS, {26'h0, acc_ctrl[i]});
            pulses(3);
            for (int j = 0; j < 3; j++) begin
                if (acc_ctrl[i][0] && int'(acc) + int'(acc_ctrl[i][5:3]) >= q) wrap = 1'b1;
                if (acc_ctrl[i][0]) acc = 3'((int'(acc) + int'(acc_ctrl[i][5:3])) % q);
            end
            rd(CPMLD_STAT_OFS, 32'h70, {25'h0, acc, 4'h0});
            wr(CPMLD_IRQ_MASK_OFS, 32'h4);
            repeat (3) @(posedge clk);
            check(irq, wrap, "irq level");
            rd(CPMLD_IRQ_STAT_OFS, 32'h4, {29'h0, wrap, 2'b00});
            repeat (3) @(posedge clk);
            check(irq, 1'b0, "irq cleared");
            wr(CPMLD_IRQ_MASK_OFS, 32'h0);
        end
        wr(CPMLD_CTRL_OFS, 32'h3);
        win_chk <= 1'b1;
        k0 = rises;
        pulses(2);
        win_chk <= 1'b0;
        check(48'(rises - k0), 48'd2, "windows");
        // Shift codes 0, 1 and 3 so every speed-up scaling check is reached
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            cn = lfsr;
            lfsr = lfsr_next(lfsr);
            ck = lfsr[3:0];
            cl = (i == 2) ? 2'd3 : 2'(i);
            wr(CPMLD_GAIN_OFS, {18'h0, ck, cl, cn});
            rd(CPMLD_GAIN_OFS, 32'h3fff, {18'h0, ck, cl, cn});
            latch <= 1'b1;
            repeat (10) @(posedge clk);
            check(dac, exp_dac(1'b0), "latch only");
            a_word <= 1'b1;
            @(posedge clk);
            a_word <= 1'b0;
            repeat (10) @(posedge clk);
            rd(CPMLD_STAT_OFS, 32'h2, 32'h2);
            check(dac, exp_dac(1'b1), "speed-up");
            latch <= 1'b0;
            repeat (10) @(posedge clk);
            check(dac, exp_dac(1'b0), "normal");
            a_word <= 1'b1;
            @(posedge clk);
            a_word <= 1'b0;
            repeat (10) @(posedge clk);
            check(dac, exp_dac(1'b0), "word, latch low");
        end
        for (int i = 0; i < 5; i++) begin
            wr(CPMLD_CTRL_OFS, {30'h0, lk[i][4:3]});
            drop_main <= lk[i][2];
            drop_aux <= lk[i][1];
            pulses(3);
            check(lock, lk[i][0], "lock flag");
        end
        stop_test();
    end
endmodule // cpmld_core_tb
